/* hdl/cpu_regfile_change_guard.sv */
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
// Overview of operation
// - Thirty-two byte-wide working registers, each read and written in one cycle.
// - Ports serve byte and word operands with byte or word results per cycle.
// - File addresses 0x1A to 0x1F also act as three 16-bit pointers.
// - Lower file address of each pointer pair holds the low byte.
// - Working registers are not reachable through the data-space register bus.
// - Loads and stores use any pointer; program loads and indirect branches use third.
// - Pointers address with fixed displacement, post-increment or pre-decrement.
// - Low-byte write goes to temp; high-byte write copies temp to low byte.
// - Low-byte read captures high byte into temp; high read returns temp.
// - The temporary register is directly readable and writable by software.
// - Protected writes and self-programming are blocked until a valid signature is written.
// - Two unlock modes, register writes and self-programming, each with its own signature.
// - Register unlock closes on other writes, nonvolatile accesses, or sleep.
// - Self-programming window lasts four instructions, closes on nonvolatile access or sleep.
// - No interrupt is serviced while a change window is open.
// - Requests during the window stay pending and are served afterwards by priority.
// - Change key register at index 0x04 resets to zero, no window open.
// - Key 0xD8 opens register unlock, 0x9D opens self-programming, others nothing.
// - Key reads bit 0 for register unlock, bit 1 for self-programming, rest zero.
module cpu_regfile_change_guard #(
  parameter int unsigned IRQ_COUNT = 8,
  parameter int unsigned IRQ_IDX_W = 3,
  parameter int unsigned WB_ADR_W = 10,
  parameter logic [15:0] SP_RESET = 16'hffff
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // Wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [WB_ADR_W-1:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic WB_ACK_O,
  output logic [31:0] WB_DAT_O,
  // Register file read ports
  input wire logic [4:0] RD_A_ADDR,
  input wire logic [4:0] RD_B_ADDR,
  output logic [7:0] RD_A_DATA,
  output logic [7:0] RD_B_DATA,
  output logic [15:0] RD_PAIR_DATA,
  // Register file write port
  input wire cpu_core_pkg::reg_wr_t REG_WR,
  // Pointer addressing
  input wire cpu_core_pkg::ptr_req_t PTR_REQ,
  output logic PTR_VALID,
  output logic [15:0] PTR_ADDR,
  // Core execution events
  input wire cpu_core_pkg::core_evt_t CORE_EVT,
  // Change guard unlock levels
  output logic IO_UNLOCK,
  output logic SPM_UNLOCK,
  // Interrupt arbitration
  input wire logic [IRQ_COUNT-1:0] IRQ_REQ,
  input wire logic [IRQ_COUNT-1:0] IRQ_LEVEL_HI,
  input wire logic IRQ_TAKEN,
  output logic INT_HOLD,
  output logic IRQ_VALID,
  output logic [IRQ_IDX_W-1:0] IRQ_INDEX
);
  ////////////////////////////////////////////////////////////////////////////////
  // Functions
  // Even file address of the pair holding a byte
  function automatic logic [4:0] pair_low(input logic [4:0] addr);
    pair_low = {addr[4:1], 1'b0};
  endfunction : pair_low
  // Low file address of a pointer
  function automatic logic [4:0] ptr_low(input cpu_core_pkg::ptr_sel_t sel);
    case (sel)
      cpu_core_pkg::PTR_FIRST: ptr_low = cpu_core_pkg::FIRST_PTR_LOW;
      cpu_core_pkg::PTR_SECOND: ptr_low = cpu_core_pkg::SECOND_PTR_LOW;
      default: ptr_low = cpu_core_pkg::THIRD_PTR_LOW;
    endcase
  endfunction : ptr_low
  // Lowest set index of a vector, with found flag
  function automatic logic [IRQ_IDX_W:0] first_set(input logic [IRQ_COUNT-1:0] vec);
    logic [IRQ_IDX_W:0] res;
    res = '0;
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (vec[i]) begin
        res = {1'b1, IRQ_IDX_W'(i)};
      end
    end
    first_set = res;
  endfunction : first_set
  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] rf_q [cpu_core_pkg::REG_COUNT];
  logic ack_q, ptr_valid_q, io_unlock_q, spm_unlock_q, int_hold_q, irq_valid_q;
  logic bus_req, bus_wr, bus_rd, ptr_wb;
  logic [31:0] rdata_q;
  logic [7:0] rd_a_q, rd_b_q, temp_q, flags_q, bus_idx, bus_wdata, key_read;
  logic [15:0] rd_pair_q, ptr_addr_q, sp_q, ptr_val, ptr_eff, ptr_new;
  cpu_core_pkg::guard_state_t guard_q, guard_d;
  logic [2:0] count_q, count_d;
  logic [IRQ_COUNT-1:0] pend_q, pend_d;
  logic [IRQ_IDX_W-1:0] irq_index_q;
  cpu_core_pkg::ptr_sel_t ptr_sel;
  cpu_core_pkg::addr_mode_t ptr_mode;
  logic [5:0] ptr_disp;
  logic [4:0] ptr_lo;
  logic [IRQ_IDX_W:0] pick_hi, pick_any;
  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone decode
  // New request accepted on the edge that raises ack
  assign bus_req = WB_CYC_I && WB_STB_I && !ack_q;
  assign bus_wr = bus_req && WB_WE_I && WB_SEL_I[0];
  assign bus_rd = bus_req && !WB_WE_I;
  assign bus_idx = WB_ADR_I[cpu_core_pkg::WB_IDX_LSB +: cpu_core_pkg::WB_IDX_W];
  assign bus_wdata = WB_DAT_I[7:0];
  // Key readback shows the open mode only
  always_comb begin
    key_read = '0;
    key_read[cpu_core_pkg::KEY_IO_BIT] = (guard_q == cpu_core_pkg::GUARD_IO);
    key_read[cpu_core_pkg::KEY_SPM_BIT] = (guard_q == cpu_core_pkg::GUARD_SPM);
  end
  // Ack one cycle after the strobe, dropped the next
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end
  // Read data; the working registers are not mapped here
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      rdata_q <= '0;
    end else if (bus_rd) begin
      case (bus_idx)
        cpu_core_pkg::IDX_TEMP: rdata_q <= {24'h0, temp_q};
        cpu_core_pkg::IDX_CHANGE_KEY: rdata_q <= {24'h0, key_read};
        cpu_core_pkg::IDX_SP_LOW: rdata_q <= {24'h0, sp_q[7:0]};
        cpu_core_pkg::IDX_SP_HIGH: rdata_q <= {24'h0, temp_q};
        cpu_core_pkg::IDX_FLAGS: rdata_q <= {24'h0, flags_q};
        default: rdata_q <= '0;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Word register access through the temporary register
  // Temp captures low writes and high byte on low reads
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      temp_q <= cpu_core_pkg::TEMP_RESET;
    end else if (bus_wr && bus_idx == cpu_core_pkg::IDX_TEMP) begin
      temp_q <= bus_wdata;
    end else if (bus_wr && bus_idx == cpu_core_pkg::IDX_SP_LOW) begin
      temp_q <= bus_wdata;
    end else if (bus_rd && bus_idx == cpu_core_pkg::IDX_SP_LOW) begin
      temp_q <= sp_q[15:8];
    end
  end
  // Stack pointer updated whole on the high-byte write
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      sp_q <= SP_RESET;
    end else if (bus_wr && bus_idx == cpu_core_pkg::IDX_SP_HIGH) begin
      sp_q <= {bus_wdata, temp_q};
    end
  end
  // Condition flags, plain storage
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      flags_q <= cpu_core_pkg::FLAGS_RESET;
    end else if (bus_wr && bus_idx == cpu_core_pkg::IDX_FLAGS) begin
      flags_q <= bus_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Pointer addressing
  // Program loads and indirect branches force the third pointer
  always_comb begin
    ptr_sel = PTR_REQ.sel;
    ptr_mode = PTR_REQ.mode;
    ptr_disp = PTR_REQ.disp;
    if (PTR_REQ.use_kind != cpu_core_pkg::USE_DATA) begin
      ptr_sel = cpu_core_pkg::PTR_THIRD;
    end
    if (PTR_REQ.use_kind == cpu_core_pkg::USE_INDIRECT_CALL ||
        PTR_REQ.use_kind == cpu_core_pkg::USE_INDIRECT_JUMP) begin
      ptr_mode = cpu_core_pkg::ADDR_DISP;
      ptr_disp = '0;
    end
  end
  // Low byte at lower address forms the pointer value
  assign ptr_lo = ptr_low(ptr_sel);
  assign ptr_val = {rf_q[ptr_lo | 5'h01], rf_q[ptr_lo]};
  // Effective address and write-back value per mode
  always_comb begin
    ptr_eff = ptr_val;
    ptr_new = ptr_val;
    ptr_wb = 1'b0;
    case (ptr_mode)
      cpu_core_pkg::ADDR_DISP: begin
        ptr_eff = ptr_val + {10'h0, ptr_disp};
      end
      cpu_core_pkg::ADDR_POSTINC: begin
        ptr_new = ptr_val + cpu_core_pkg::PTR_STEP;
        ptr_wb = PTR_REQ.valid;
      end
      cpu_core_pkg::ADDR_PREDEC: begin
        ptr_eff = ptr_val - cpu_core_pkg::PTR_STEP;
        ptr_new = ptr_val - cpu_core_pkg::PTR_STEP;
        ptr_wb = PTR_REQ.valid;
      end
      default: begin
        ptr_eff = ptr_val;
      end
    endcase
  end
  // Registered pointer address output
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ptr_valid_q <= 1'b0;
      ptr_addr_q <= '0;
    end else begin
      ptr_valid_q <= PTR_REQ.valid;
      ptr_addr_q <= PTR_REQ.valid ? ptr_eff : ptr_addr_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Register file
  // Byte or word result; pointer update overrides its own pair
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      for (int i = 0; i < cpu_core_pkg::REG_COUNT; i++) begin
        rf_q[i] <= '0;
      end
    end else begin
      if (REG_WR.valid && REG_WR.wide) begin
        rf_q[pair_low(REG_WR.addr)] <= REG_WR.data[7:0];
        rf_q[pair_low(REG_WR.addr) | 5'h01] <= REG_WR.data[15:8];
      end else if (REG_WR.valid) begin
        rf_q[REG_WR.addr] <= REG_WR.data[7:0];
      end
      if (ptr_wb) begin
        rf_q[ptr_lo] <= ptr_new[7:0];
        rf_q[ptr_lo | 5'h01] <= ptr_new[15:8];
      end
    end
  end
  // Two byte operands and one word operand each cycle
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      rd_a_q <= '0;
      rd_b_q <= '0;
      rd_pair_q <= '0;
    end else begin
      rd_a_q <= rf_q[RD_A_ADDR];
      rd_b_q <= rf_q[RD_B_ADDR];
      rd_pair_q <= {rf_q[pair_low(RD_A_ADDR) | 5'h01], rf_q[pair_low(RD_A_ADDR)]};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Change guard
  // Window open, count, early close and reopen by signature
  always_comb begin
    guard_d = guard_q;
    count_d = count_q;
    if (guard_q != cpu_core_pkg::GUARD_IDLE && CORE_EVT.instr_done) begin
      if (count_q == cpu_core_pkg::WINDOW_LAST) begin
        guard_d = cpu_core_pkg::GUARD_IDLE;
      end else begin
        count_d = count_q - 3'h1;
      end
    end
    if (guard_q == cpu_core_pkg::GUARD_IO &&
        (bus_wr || CORE_EVT.data_write || CORE_EVT.nvm_access || CORE_EVT.sleep_exec)) begin
      guard_d = cpu_core_pkg::GUARD_IDLE;
    end
    if (guard_q == cpu_core_pkg::GUARD_SPM && (CORE_EVT.nvm_access || CORE_EVT.sleep_exec)) begin
      guard_d = cpu_core_pkg::GUARD_IDLE;
    end
    if (bus_wr && bus_idx == cpu_core_pkg::IDX_CHANGE_KEY) begin
      count_d = cpu_core_pkg::WINDOW_INSTR;
      case (bus_wdata)
        cpu_core_pkg::KEY_IO_UNLOCK: guard_d = cpu_core_pkg::GUARD_IO;
        cpu_core_pkg::KEY_SPM_UNLOCK: guard_d = cpu_core_pkg::GUARD_SPM;
        default: guard_d = cpu_core_pkg::GUARD_IDLE;
      endcase
    end
  end
  // Guard state, reset closed
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      guard_q <= cpu_core_pkg::GUARD_IDLE;
      count_q <= '0;
    end else begin
      guard_q <= guard_d;
      count_q <= count_d;
    end
  end
  // Unlock levels to protected registers and the nonvolatile controller
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      io_unlock_q <= 1'b0;
      spm_unlock_q <= 1'b0;
    end else begin
      io_unlock_q <= (guard_d == cpu_core_pkg::GUARD_IO);
      spm_unlock_q <= (guard_d == cpu_core_pkg::GUARD_SPM);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt hold and arbitration
  // Set wins over clear for pending flags
  always_comb begin
    pend_d = pend_q;
    if (IRQ_TAKEN && irq_valid_q) begin
      pend_d[irq_index_q] = 1'b0;
    end
    pend_d = pend_d | IRQ_REQ;
  end
  assign pick_hi = first_set(pend_d & IRQ_LEVEL_HI);
  assign pick_any = first_set(pend_d);
  // Pending flags
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end
  // Offer the best pending request only while no window is open
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      int_hold_q <= 1'b0;
      irq_valid_q <= 1'b0;
      irq_index_q <= '0;
    end else begin
      int_hold_q <= (guard_d != cpu_core_pkg::GUARD_IDLE);
      irq_valid_q <= pick_any[IRQ_IDX_W] && guard_d == cpu_core_pkg::GUARD_IDLE;
      irq_index_q <= pick_hi[IRQ_IDX_W] ? pick_hi[IRQ_IDX_W-1:0] : pick_any[IRQ_IDX_W-1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;
  assign RD_A_DATA = rd_a_q;
  assign RD_B_DATA = rd_b_q;
  assign RD_PAIR_DATA = rd_pair_q;
  assign PTR_VALID = ptr_valid_q;
  assign PTR_ADDR = ptr_addr_q;
  assign IO_UNLOCK = io_unlock_q;
  assign SPM_UNLOCK = spm_unlock_q;
  assign INT_HOLD = int_hold_q;
  assign IRQ_VALID = irq_valid_q;
  assign IRQ_INDEX = irq_index_q;
endmodule : cpu_regfile_change_guard

/* hdl/cpu_core_pkg.sv */
package cpu_core_pkg;

  // Register file geometry
  localparam int unsigned REG_COUNT = 32;
  localparam int unsigned REG_ADDR_W = 5;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;

  // Pointer pair low-byte file addresses
  localparam logic [4:0] FIRST_PTR_LOW = 5'h1a;
  localparam logic [4:0] SECOND_PTR_LOW = 5'h1c;
  localparam logic [4:0] THIRD_PTR_LOW = 5'h1e;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // Register indices; byte address is four times the index
  localparam int unsigned WB_IDX_LSB = 2;
  localparam int unsigned WB_IDX_W = 8;
  localparam logic [7:0] IDX_TEMP = 8'h01;
  localparam logic [7:0] IDX_CHANGE_KEY = 8'h04;
  localparam logic [7:0] IDX_SP_LOW = 8'h0d;
  localparam logic [7:0] IDX_SP_HIGH = 8'h0e;
  localparam logic [7:0] IDX_FLAGS = 8'h0f;

  // Reset values
  localparam logic [7:0] CHANGE_KEY_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;

  // Change guard signatures and window length
  localparam logic [7:0] KEY_IO_UNLOCK = 8'hd8;
  localparam logic [7:0] KEY_SPM_UNLOCK = 8'h9d;
  localparam logic [2:0] WINDOW_INSTR = 3'h4;
  localparam logic [2:0] WINDOW_LAST = 3'h1;
  localparam int unsigned KEY_IO_BIT = 0;
  localparam int unsigned KEY_SPM_BIT = 1;

  // Pointer selection, addressing mode and use
  typedef enum logic [1:0] {PTR_FIRST, PTR_SECOND, PTR_THIRD} ptr_sel_t;
  typedef enum logic [1:0] {ADDR_DISP, ADDR_POSTINC, ADDR_PREDEC} addr_mode_t;
  typedef enum logic [1:0] {USE_DATA, USE_PROG_LOAD, USE_INDIRECT_CALL, USE_INDIRECT_JUMP} ptr_use_t;

  // Change guard states
  typedef enum logic [1:0] {GUARD_IDLE, GUARD_IO, GUARD_SPM} guard_state_t;

  // Pointer request from the core
  typedef struct packed {
    logic valid;
    ptr_sel_t sel;
    addr_mode_t mode;
    ptr_use_t use_kind;
    logic [5:0] disp;
  } ptr_req_t;

  // Register file write from the core
  typedef struct packed {
    logic valid;
    logic wide;
    logic [4:0] addr;
    logic [15:0] data;
  } reg_wr_t;

  // Execution events from the core, one-cycle pulses
  typedef struct packed {
    logic instr_done;
    logic data_write;
    logic nvm_access;
    logic sleep_exec;
  } core_evt_t;

endpackage : cpu_core_pkg

/* test/cpu_regfile_change_guard_assertions.sv */
`timescale 1ns/10ps
module cpu_regfile_change_guard_assertions #(
  parameter int unsigned WB_ADR_W = 10
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // Register bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [WB_ADR_W-1:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  // Core side
  input wire cpu_core_pkg::ptr_req_t PTR_REQ,
  input wire logic PTR_VALID,
  input wire cpu_core_pkg::core_evt_t CORE_EVT,
  // Guard outputs
  input wire logic IO_UNLOCK,
  input wire logic SPM_UNLOCK,
  input wire logic INT_HOLD,
  input wire logic IRQ_VALID
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  ////////////////////
  // Decoded bus requests and window closers
  logic take, key_adr, key_wr, shut, nv_sl;
  logic [2:0] cnt_q;
  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign key_adr = WB_ADR_I[cpu_core_pkg::WB_IDX_LSB +: cpu_core_pkg::WB_IDX_W] == 8'h04;
  assign key_wr = take && WB_WE_I && WB_SEL_I[0] && key_adr;
  assign nv_sl = CORE_EVT.nvm_access || CORE_EVT.sleep_exec;
  assign shut = nv_sl || CORE_EVT.data_write || (take && WB_WE_I && WB_SEL_I[0] && !key_adr);
  // Instructions executed inside an open window
  always_ff @(posedge REF_CLK) begin
    if (SRST || key_wr || !(IO_UNLOCK || SPM_UNLOCK)) begin
      cnt_q <= 3'h0;
    end else if (CORE_EVT.instr_done) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  ////////////////////
  chk_ack_one_cycle: assert property (
    take |=> WB_ACK_O ##1 !WB_ACK_O) else $error("bus ack not a single pulse");
  chk_key_io_open: assert property (
    key_wr && WB_DAT_I[7:0] == cpu_core_pkg::KEY_IO_UNLOCK |=> IO_UNLOCK && !SPM_UNLOCK
    && INT_HOLD) else $error("io key did not open the io window");
  chk_key_spm_open: assert property (
    key_wr && WB_DAT_I[7:0] == cpu_core_pkg::KEY_SPM_UNLOCK |=> SPM_UNLOCK && !IO_UNLOCK)
    else $error("spm key did not open the spm window");
  chk_bad_key_shut: assert property (
    key_wr && WB_DAT_I[7:0] != 8'hd8 && WB_DAT_I[7:0] != 8'h9d |=> !IO_UNLOCK && !SPM_UNLOCK)
    else $error("bad key left a window open");
  chk_key_readback: assert property (
    WB_ACK_O && !WB_WE_I && key_adr |-> WB_DAT_O == {30'h0, $past(SPM_UNLOCK), $past(IO_UNLOCK)})
    else $error("key readback wrong");
  chk_io_shut: assert property (
    IO_UNLOCK && shut && !key_wr |=> !IO_UNLOCK) else $error("io window not closed");
  chk_spm_shut: assert property (
    SPM_UNLOCK && nv_sl && !key_wr |=> !SPM_UNLOCK) else $error("spm window not closed");
  chk_spm_keeps: assert property (
    SPM_UNLOCK && !nv_sl && !CORE_EVT.instr_done && !take |=> SPM_UNLOCK)
    else $error("spm window closed early");
  chk_hold_no_irq: assert property (
    INT_HOLD |-> !IRQ_VALID && (IO_UNLOCK || SPM_UNLOCK)) else $error("irq offered in window");
  chk_window_len: assert property (
    IO_UNLOCK || SPM_UNLOCK |-> cnt_q < cpu_core_pkg::WINDOW_INSTR) else $error("window too long");
  chk_ptr_answer: assert property (
    PTR_VALID == $past(PTR_REQ.valid)) else $error("pointer answer timing wrong");
endmodule : cpu_regfile_change_guard_assertions

/* test/core_model.sv */
`timescale 1ns/10ps
module core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Commands from the bench
  input wire logic run,
  input wire logic [2:0] kick,
  input wire logic [3:0] delay,
  // Design side
  input wire logic irq_valid,
  output cpu_core_pkg::core_evt_t evt,
  output logic irq_taken
);
  logic [3:0] wait_q;
  ////////////////////
  // One pulse per executed instruction or access
  always_ff @(posedge clk) begin
    if (srst) begin
      evt <= '0;
    end else begin
      evt <= {run, kick};
    end
  end
  // Take an offered request after a stall
  always_ff @(posedge clk) begin
    if (srst || !irq_valid || irq_taken) begin
      wait_q <= 4'h0;
      irq_taken <= 1'b0;
    end else if (wait_q == delay) begin
      irq_taken <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : core_model

/* test/cpu_regfile_change_guard_tb.sv */
`timescale 1ns/10ps
module cpu_regfile_change_guard_tb;
  localparam logic [15:0] SP_INIT = 16'hffff;
  logic clk, srst, cyc, stb, we, ack, pval, iou, spu, run, taken, hold, ival;
  logic [9:0] adr;
  logic [31:0] dat_i, dat_o;
  logic [3:0] sel, dly;
  logic [4:0] ra, rb;
  logic [7:0] rda, rdb, irq, lvl, lo, hi, mem [32];
  logic [15:0] rdp, paddr, p1, p2, p3;
  logic [2:0] iidx, kick;
  cpu_core_pkg::reg_wr_t rwr;
  cpu_core_pkg::ptr_req_t preq;
  cpu_core_pkg::core_evt_t evt;
  logic [31:0] exp_q [$];
  logic [15:0] ptr_q [$];
  logic [2:0] irq_q [$];
  int n_mismatch, samples_checked;
  ////////////////////
  // Design and core model
  cpu_regfile_change_guard #(.SP_RESET(SP_INIT)) cpu_regfile_change_guard_inst (
    .REF_CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_DAT_I(dat_i), .WB_SEL_I(sel), .WB_ACK_O(ack), .WB_DAT_O(dat_o),
    .RD_A_ADDR(ra), .RD_B_ADDR(rb), .RD_A_DATA(rda), .RD_B_DATA(rdb), .RD_PAIR_DATA(rdp),
    .REG_WR(rwr), .PTR_REQ(preq), .PTR_VALID(pval), .PTR_ADDR(paddr), .CORE_EVT(evt),
    .IO_UNLOCK(iou), .SPM_UNLOCK(spu), .IRQ_REQ(irq), .IRQ_LEVEL_HI(lvl), .IRQ_TAKEN(taken),
    .INT_HOLD(hold), .IRQ_VALID(ival), .IRQ_INDEX(iidx));
  core_model core_model_inst (.clk(clk), .srst(srst), .run(run), .kick(kick), .delay(dly),
    .irq_valid(ival), .evt(evt), .irq_taken(taken));
  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Classic cycle; for a read d is the expected byte
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
    input logic [3:0] s = 4'h1);
    int n = 0;
    if (!w) exp_q.push_back({24'h0, d});
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    dat_i <= {24'h0, d};
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) chk("bus_timeout", 32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Run n instructions or pulse one access kind
  task automatic ev(input int n, input logic [2:0] k);
    @(posedge clk);
    run <= n > 0;
    kick <= k;
    repeat (n > 0 ? n : 1) @(posedge clk);
    run <= 1'b0;
    kick <= 3'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : ev
  task automatic pq(input logic [5:0] smu, input logic [5:0] d, input logic [15:0] e);
    ptr_q.push_back(e);
    @(posedge clk);
    preq <= {1'b1, smu, d};
    @(posedge clk);
    preq.valid <= 1'b0;
  endtask : pq
  task automatic pair(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    ra <= a;
    @(posedge clk);
    @(negedge clk);
    chk("pair", e, rdp);
  endtask : pair
  task automatic print_verdict;
    chk("queues", 32'h0, exp_q.size() + ptr_q.size() + irq_q.size());
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  ////////////////////
  // Result monitor against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0)
      chk("rd_data", exp_q.size() ? exp_q.pop_front() : 'x, dat_o);
    if (pval === 1'b1)
      chk("ptr_addr", ptr_q.size() ? ptr_q.pop_front() : 'x, paddr);
    if (taken === 1'b1 && ival === 1'b1)
      chk("irq", irq_q.size() ? irq_q.pop_front() : 'x, iidx);
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  ////////////////////
  initial begin
    {cyc, stb, we, adr, dat_i, sel, ra, rb, rwr, preq, run, kick, irq} = '0;
    {srst, dly, lvl} = {1'b1, 4'h3, 8'h20};
    void'($urandom(71491));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    // Reset values, word access through temp, byte lane and unmapped places
    wb(0, 8'h04, 8'h00);
    wb(0, 8'h0d, SP_INIT[7:0]);
    wb(0, 8'h0e, SP_INIT[15:8]);
    wb(0, 8'h02, 8'h00);
    lo = 8'($urandom);
    hi = 8'($urandom);
    wb(1, 8'h0d, lo);
    wb(0, 8'h01, lo);
    wb(1, 8'h0e, hi);
    wb(0, 8'h0d, lo);
    wb(1, 8'h01, 8'h3c);
    wb(0, 8'h0e, 8'h3c);
    wb(0, 8'h0d, lo);
    wb(0, 8'h0e, hi);
    wb(1, 8'h0f, 8'ha5, 4'he);
    wb(0, 8'h0f, 8'h00);
    wb(1, 8'h0f, hi);
    wb(0, 8'h0f, hi);
    // Working registers, back to back writes then dual reads
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'($urandom);
      @(posedge clk);
      rwr <= {2'h2, 5'(i), 8'h00, mem[i]};
    end
    @(posedge clk);
    rwr.valid <= 1'b0;
    wb(1, 8'h1a, 8'h5a);
    wb(0, 8'h1a, 8'h00);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      ra <= 5'(i);
      rb <= 5'(31 - i);
      @(posedge clk);
      @(negedge clk);
      chk("rd_a", mem[i], rda);
      chk("rd_b", mem[31 - i], rdb);
    end
    // Pointers in every mode and use
    p1 = 16'($urandom);
    p2 = 16'($urandom);
    p3 = 16'($urandom);
    @(posedge clk);
    rwr <= {2'h3, 5'h1a, p1};
    @(posedge clk);
    rwr <= {2'h3, 5'h1c, p2};
    @(posedge clk);
    rwr <= {2'h3, 5'h1e, p3};
    @(posedge clk);
    rwr.valid <= 1'b0;
    pair(5'h1b, p1);
    pq(6'h00, 6'h05, p1 + 16'h5);
    pq(6'h14, 6'h00, p2);
    p2 = p2 + 16'h1;
    pq(6'h10, 6'h00, p2);
    pq(6'h08, 6'h00, p1 - 16'h1);
    p1 = p1 - 16'h1;
    pq(6'h01, 6'h00, p3);
    pq(6'h16, 6'h03, p3);
    pq(6'h0b, 6'h00, p3);
    pq(6'h24, 6'h00, p3);
    p3 = p3 + 16'h1;
    pq(6'h20, 6'h3f, p3 + 16'h3f);
    pair(5'h1a, p1);
    pair(5'h1f, p3);
    // Register unlock window holds requests for four instructions
    wb(1, 8'h04, 8'hd8);
    @(negedge clk);
    chk("io_open", 32'h3, {hold, iou});
    wb(0, 8'h04, 8'h01);
    irq_q = {3'h5, 3'h2};
    @(posedge clk);
    irq <= 8'h24;
    @(posedge clk);
    irq <= 8'h00;
    ev(3, 3'h0);
    chk("io_window", 32'h2, {iou, ival});
    ev(1, 3'h0);
    chk("io_expired", 32'h0, iou);
    repeat (20) @(posedge clk);
    chk("irq_served", 32'h0, irq_q.size());
    // Each closing access, for both modes
    for (int k = 0; k < 3; k++) begin
      wb(1, 8'h04, 8'hd8);
      ev(0, 3'h4 >> k);
      chk("io_shut", 32'h0, iou);
      wb(1, 8'h04, 8'h9d);
      wb(0, 8'h04, 8'h02);
      ev(0, 3'h4 >> k);
      chk("spm_shut", k == 0, spu);
    end
    wb(1, 8'h04, 8'hd8);
    wb(1, 8'h0f, 8'h00);
    @(negedge clk);
    chk("io_bus_shut", 32'h0, iou);
    wb(1, 8'h04, 8'h9d);
    ev(4, 3'h0);
    chk("spm_expired", 32'h0, spu);
    wb(1, 8'h04, 8'h9d);
    wb(1, 8'h04, 8'h55);
    @(negedge clk);
    chk("bad_key", 32'h0, {iou, spu});
    wb(0, 8'h04, 8'h00);
    repeat (20) @(posedge clk);
    print_verdict();
  end
endmodule : cpu_regfile_change_guard_tb
bind cpu_regfile_change_guard cpu_regfile_change_guard_assertions #(.WB_ADR_W(WB_ADR_W))
  cpu_regfile_change_guard_assertions_inst (.REF_CLK(REF_CLK), .SRST(SRST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O),
  .PTR_REQ(PTR_REQ), .PTR_VALID(PTR_VALID), .CORE_EVT(CORE_EVT), .IO_UNLOCK(IO_UNLOCK),
  .SPM_UNLOCK(SPM_UNLOCK), .INT_HOLD(INT_HOLD), .IRQ_VALID(IRQ_VALID));
